// File: logic/p0rx_pkg.sv
// Purpose: Shared constants and types for the port 0 receive input stage
// Assumes: One clock domain, inputs synchronous to it
// Notes: Modes, word layout and FIFO depth live here
package p0rx_pkg;

    localparam int P0RX_NIB_W = 4;
    localparam int P0RX_DIB_W = 2;
    localparam int P0RX_FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        P0RX_MODE_MII_MAC = 2'h0,
        P0RX_MODE_MII_PHY = 2'h1,
        P0RX_MODE_RMII_PHY = 2'h2
    } p0rx_mode_t;

    // One beat from the pins
    typedef struct packed {
        logic valid;
        logic error;
        logic [P0RX_NIB_W-1:0] data;
    } p0rx_pins_t;

    // One word towards the switch
    typedef struct packed {
        logic sof;
        logic eof;
        logic error;
        logic abort;
        logic dibit;
        logic [P0RX_NIB_W-1:0] data;
    } p0rx_word_t;

    localparam int P0RX_WORD_W = $bits(p0rx_word_t);

    localparam logic [P0RX_NIB_W-1:0] P0RX_NIB_ZERO = 4'h0;
    localparam logic [P0RX_NIB_W-1:0] P0RX_DIB_MASK = 4'h3;

endpackage

// File: logic/p0rx_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: Full drops in_ready_o; empty drops out_valid_o
`timescale 1ns/1ps
module p0rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic [AW:0] fill = wr_ptr - rd_ptr;
    wire logic full = (fill == (AW+1)'(DEPTH));
    wire logic empty = (fill == '0);
    wire logic push = in_valid_i && !full;
    wire logic pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
endmodule

// File: logic/p0rx_input.sv
// Purpose: Port 0 MII/RMII input stage towards the switch
// Assumes: Pins synchronous to ref_clk_i; mode and isolate quasi-static
// Notes: Words pass a FIFO; stall on full drops beats and marks an abort
`timescale 1ns/1ps
//
// Operation
// - In MII MAC mode the four input data bits are receive data from the PHY.
// - In MII PHY mode the four input data bits are the MAC transmit nibble taken in.
// - In RMII PHY mode only the low two data bits count and upper bits and error are ignored.
// - In MII MAC mode data and error count only while the valid input is high.
// - In MII PHY mode data and error are qualified by the valid input.
// - In MII MAC mode an error while valid marks a receive error in the current frame.
// - In MII PHY mode an error while valid aborts the frame in progress.
// - With isolate set in a PHY mode the data, valid and error inputs are ignored.
// - The input reference clock times all inputs, from the PHY or from the device.
module p0rx_input import p0rx_pkg::*; #(
    parameter int FIFO_DEPTH = P0RX_FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic virtual_phy_isolate_i,
    input wire logic [P0RX_NIB_W-1:0] port0_in_nibble_i,
    input wire logic port0_in_valid_i,
    input wire logic port0_in_error_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic [P0RX_WORD_W-1:0] out_word_o,
    output logic overflow_o,
    output logic isolated_o
);
    ////////////////////////////////////////////////////////////////////
    // Input sampling
    p0rx_pins_t pins;
    p0rx_pins_t pin_beat;
    p0rx_mode_t mode;
    logic iso;

    // True in RMII PHY mode: only the low lanes carry data
    function automatic logic mode_is_rmii(input p0rx_mode_t m);
        return (m == P0RX_MODE_RMII_PHY);
    endfunction

    // True in either PHY mode, where isolate applies
    function automatic logic mode_is_phy(input p0rx_mode_t m);
        return (m != P0RX_MODE_MII_MAC);
    endfunction

    // True in MII PHY mode, where the error input aborts
    function automatic logic mode_is_mii_phy(input p0rx_mode_t m);
        return (m == P0RX_MODE_MII_PHY);
    endfunction

    // True in MII MAC mode, where the error input marks the frame
    function automatic logic mode_is_mac(input p0rx_mode_t m);
        return (m == P0RX_MODE_MII_MAC);
    endfunction

    // Keeps the low lanes only when a dibit is carried
    function automatic logic [P0RX_NIB_W-1:0] lane_select(
        input logic rmii,
        input logic [P0RX_NIB_W-1:0] d
    );
        return rmii ? (d & P0RX_DIB_MASK) : d;
    endfunction

    assign pin_beat = '{
        valid: port0_in_valid_i,
        error: port0_in_error_i,
        data: port0_in_nibble_i
    };

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins <= '0;
        end else begin
            pins <= pin_beat;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= P0RX_MODE_MII_MAC;
        end else begin
            mode <= p0rx_mode_t'(mode_i);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            iso <= 1'b0;
        end else begin
            iso <= virtual_phy_isolate_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Qualification
    logic is_rmii;
    logic is_phy;
    logic gated;
    logic q_valid;
    logic q_error;
    logic [P0RX_NIB_W-1:0] q_data;
    logic rx_err;
    logic tx_abort;

    assign is_rmii = mode_is_rmii(mode);
    assign is_phy = mode_is_phy(mode);
    assign gated = is_phy && iso;
    assign q_valid = pins.valid && !gated;
    assign q_error = q_valid && pins.error && !is_rmii;
    assign q_data = q_valid ? lane_select(is_rmii, pins.data) :
        P0RX_NIB_ZERO;
    assign rx_err = q_error && mode_is_mac(mode);
    assign tx_abort = q_error && mode_is_mii_phy(mode);

    ////////////////////////////////////////////////////////////////////
    // Frame tracking
    logic in_frame;
    logic aborted;
    logic next_aborted;
    logic starting;
    logic ending;
    logic push;
    logic drop;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [P0RX_WORD_W-1:0] fifo_data;
    p0rx_word_t word;

    assign starting = q_valid && !in_frame;
    assign ending = in_frame && !q_valid;
    // Beats after an abort are not forwarded; the end marker still is
    assign push = (q_valid && !(aborted && !starting)) || ending;
    // Only a word that should have gone in counts as lost
    assign drop = push && !fifo_ready;
    assign next_aborted = q_valid ? ((aborted && !starting) || tx_abort || drop) : 1'b0;

    assign word = '{
        sof: starting,
        eof: ending,
        error: rx_err,
        abort: tx_abort || aborted || drop,
        dibit: is_rmii,
        data: q_data
    };

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= q_valid;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aborted <= 1'b0;
        end else begin
            aborted <= next_aborted;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Buffer towards the switch
    p0rx_fifo #(
        .WIDTH(P0RX_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i(word),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Output register stage
    logic out_take_ok;
    logic next_out_valid;

    assign out_take_ok = !out_valid_o || out_ready_i;
    assign next_out_valid = fifo_valid && out_ready_i;
    assign fifo_pop = out_ready_i && out_take_ok;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
        end else if (out_take_ok) begin
            out_valid_o <= next_out_valid;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_word_o <= '0;
        end else if (out_take_ok) begin
            out_word_o <= fifo_data;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_o <= 1'b0;
        end else begin
            overflow_o <= drop;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            isolated_o <= 1'b0;
        end else begin
            isolated_o <= gated;
        end
    end
endmodule

// File: bench/p0rx_far_end.sv
// Purpose: Far-side MAC or PHY driving the port 0 input pins
// Assumes: Caller changes requests at the falling edge
// Notes: Released lines fall to the pull-down level
`timescale 1ns/1ps
module p0rx_far_end (
    input wire logic snd_i,
    input wire logic [4:0] beat_i,
    output logic [3:0] nib_o,
    output logic dv_o,
    output logic er_o
);
    assign dv_o = snd_i;
    assign nib_o = snd_i ? beat_i[3:0] : 4'h0;
    assign er_o = snd_i & beat_i[4];
endmodule

// File: bench/p0rx_input_props.sv
// Purpose: Port checks for the port 0 input stage
// Assumes: One clock, reset high
// Notes: Bound to every p0rx_input
`timescale 1ns/1ps
module p0rx_input_props import p0rx_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic virtual_phy_isolate_i,
    input wire logic out_ready_i,
    input wire logic out_valid_o,
    input wire logic [P0RX_WORD_W-1:0] out_word_o,
    input wire logic isolated_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_iso_flag_set: assert property ((virtual_phy_isolate_i && mode_i == 2'h1)[*3] |-> isolated_o)
        else $error("isolate flag missing");
    a_mac_not_iso: assert property ((mode_i == 2'h0)[*3] |-> !isolated_o)
        else $error("isolate flag in mac mode");
    a_dibit_upper: assert property (out_valid_o && out_word_o[4] |-> out_word_o[3:2] == 2'h0)
        else $error("dibit upper bits set");
    a_dibit_no_err: assert property (out_valid_o && out_word_o[4] |-> !out_word_o[6])
        else $error("dibit carries error");
    a_word_stands: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_word_o))
        else $error("word changed under stall");
    a_sof_eof_apart: assert property (out_valid_o |-> !(out_word_o[8] && out_word_o[7]))
        else $error("sof and eof together");
    a_eof_data_zero: assert property (out_valid_o && out_word_o[7] |-> out_word_o[3:0] == 4'h0)
        else $error("eof word carries data");
    a_rise_ready: assert property ($rose(out_valid_o) |-> $past(out_ready_i))
        else $error("valid rose without ready");
endmodule
bind p0rx_input p0rx_input_props u_props (.ref_clk_i, .rst_i, .mode_i, .virtual_phy_isolate_i,
    .out_ready_i, .out_valid_o, .out_word_o, .isolated_o);

// File: bench/p0rx_input_bench.sv
// Purpose: Self-checking bench for the port 0 input stage
// Assumes: Far side driven at the falling edge
// Notes: Words are collected as they leave
`timescale 1ns/1ps
module p0rx_input_bench;
    import p0rx_pkg::*;
    logic ref_clk_i = 0, rst_i = 1, iso = 0, rdy = 1, snd = 0, dv, er, ovv, ovf, isd, seen = 0;
    logic [1:0] mode = 2'h0;
    logic [4:0] bt = 5'h00;
    logic [3:0] nib;
    logic [8:0] wd, got[$], e[$];
    int error_cnt = 0, checks = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    p0rx_far_end far (.snd_i(snd), .beat_i(bt), .nib_o(nib), .dv_o(dv), .er_o(er));
    p0rx_input dut (.ref_clk_i, .rst_i, .mode_i(mode), .virtual_phy_isolate_i(iso),
        .port0_in_nibble_i(nib), .port0_in_valid_i(dv), .port0_in_error_i(er), .out_ready_i(rdy),
        .out_valid_o(ovv), .out_word_o(wd), .overflow_o(ovf), .isolated_o(isd));
    always @(posedge ref_clk_i) begin
        if (ovv === 1'b1 && rdy) got.push_back(wd);
        if (ovf === 1'b1) seen = 1;
    end
    task chk(input string n, input logic [8:0] x, input logic [8:0] g);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, x, g);
        end
    endtask
    task frame(input logic [19:0] f);
        got = {};
        for (int i = 3; i >= 0; i--) begin
            @(negedge ref_clk_i) snd = 1;
            bt = f[i*5+:5];
        end
        @(negedge ref_clk_i) snd = 0;
        repeat (14) @(negedge ref_clk_i);
    endtask
    task cmp(input string n);
        foreach (e[i]) chk(n, e[i], got[i]);
        $display("%s done", n);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #4000;
        error_cnt++;
        end_sim();
    end
    task t_mac;
        mode = 2'h0;
        frame({5'h05, 5'h1a, 5'h03, 5'h06});
        e = '{9'h105, 9'h04a, 9'h003, 9'h006, 9'h080};
        chk("count", 9'h005, 9'(got.size()));
        cmp("mac");
    endtask
    task t_stall;
        fork
            frame({5'h07, 5'h08, 5'h09, 5'h0a});
            begin
                repeat (6) @(negedge ref_clk_i);
                rdy = 0;
                repeat (3) @(negedge ref_clk_i);
                rdy = 1;
            end
        join
        e = '{9'h107, 9'h008, 9'h009, 9'h00a, 9'h080};
        chk("stall count", 9'h005, 9'(got.size()));
        cmp("stall");
    endtask
    task t_phy;
        mode = 2'h1;
        frame({5'h01, 5'h02, 5'h13, 5'h04});
        e = '{9'h101, 9'h002, 9'h023, 9'h0a0};
        seen = 0;
        foreach (got[i]) seen = seen | got[i][5];
        chk("abort", 9'h001, {8'h00, seen});
        chk("phy count", 9'h004, 9'(got.size()));
        cmp("phy");
    endtask
    task t_rmii;
        mode = 2'h2;
        frame({5'h1f, 5'h1e, 5'h0d, 5'h0c});
        e = '{9'h113, 9'h012, 9'h011, 9'h010, 9'h090};
        cmp("rmii");
    endtask
    task t_iso;
        mode = 2'h1;
        iso = 1;
        frame({5'h01, 5'h02, 5'h03, 5'h04});
        chk("iso count", 9'h000, 9'(got.size()));
        chk("iso flag", 9'h001, {8'h00, isd});
        iso = 0;
        $display("iso done");
    endtask
    task t_fill;
        seen = 0;
        rdy = 0;
        snd = 1;
        for (int i = 0; i < 40; i++) @(negedge ref_clk_i) bt = 5'(i % 16);
        snd = 0;
        chk("overflow", 9'h001, {8'h00, seen});
        rdy = 1;
        repeat (60) @(negedge ref_clk_i);
        chk("drained", 9'h000, {8'h00, ovv});
        $display("fill done");
    endtask
    initial begin
        repeat (6) @(negedge ref_clk_i);
        rst_i = 0;
        t_mac();
        t_stall();
        t_phy();
        t_rmii();
        t_iso();
        t_fill();
        end_sim();
    end
endmodule
